// *** src/channel_drive_pkg.sv ***
// constants and types for the channel drive configuration register
// Overview of operation
// - With the cut-off bit at 1 the last chained device silences its serial output except for readback; at 0 it shifts data out.
// - Bit 1 picks the channel current ceiling, 0 for 10 mA and 1 for 20 mA, and resets to 0.
// - Bit 14 resets to 1 and, when set, makes lines 16 to 31 run in descending order.
// - Bits 16, 17 and 18 enable the fine compensation range for red, green and blue, each resetting to 0.
// - Bits 19 to 21 pick slow (0) or fast (1) turn-off slew for red, green and blue, each resetting to 0.
// - Fields 23-22, 25-24 and 27-26 pick turn-on slew for red, green and blue, from slower to faster, each resetting to 01b.
// - Bits 32, 33 and 34 enable the coarse compensation range for red, green and blue, each resetting to 0.
// - Field 38-35 sets the first-line dim level as value plus one and resets to 0000b.
// - Bit 39 enables isolation between switching-on and switching-off channels and resets to 0.
// - Field 43-40 sets the isolation boost level as value plus one and resets to 1000b.
// - Bit 44 turns the isolation boost on at the programmed level and resets to 0.
package channel_drive_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [3:0]  ADDR_CFG_LO    = 4'h0;
    localparam logic [3:0]  ADDR_CFG_MID   = 4'h4;
    localparam logic [3:0]  ADDR_CFG_HI    = 4'h8;
    localparam logic [3:0]  ADDR_STATUS    = 4'hC;
    localparam logic [47:0] CFG_RESET      = 48'h0800_0540_403C;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_CUTOFF      = 0;
    localparam int POS_CEILING     = 1;
    localparam int POS_SCAN_ORDER_REVERSE    = 14;
    localparam int POS_FINE        = 16;
    localparam int POS_OFF_SLEW    = 19;
    localparam int POS_ON_SLEW     = 22;
    localparam int POS_COARSE      = 32;
    localparam int POS_FIRST_DIM   = 35;
    localparam int POS_ISO_EN      = 39;
    localparam int POS_BOOST_LVL   = 40;
    localparam int POS_BOOST_EN    = 44;
    localparam logic [4:0] LINE_HALF = 5'h10;
    localparam logic [4:0] LINE_LAST = 5'h1F;

    typedef enum logic [1:0] {
        SLEW_SLOWER = 2'h0,
        SLEW_SLOW   = 2'h1,
        SLEW_FAST   = 2'h2,
        SLEW_FASTER = 2'h3
    } on_slew_t;

    typedef struct packed {
        logic       chain_end_output_cutoff;
        logic       current_ceiling_select;
        logic       scan_order_reverse;
        logic [2:0] fine_enable;
        logic [2:0] turnoff_fast;
        on_slew_t   red_turnon_slew;
        on_slew_t   green_turnon_slew;
        on_slew_t   blue_turnon_slew;
        logic [2:0] coarse_enable;
        logic [4:0] first_line_dim_level;
        logic       on_off_isolation_enable;
        logic [4:0] isolation_boost_level;
    } drive_ctrl_t;

endpackage

// *** src/channel_drive_config.sv ***
// channel drive configuration register with decoded controls
module channel_drive_config
    import channel_drive_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [3:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [31:0] rdata,
    input  wire logic        is_last_device,
    input  wire logic        readback_cmd,
    input  wire logic        shift_data,
    output logic             chain_serial_out,
    input  wire logic [4:0]  logical_line,
    output logic      [4:0]  physical_line,
    output drive_ctrl_t      ctrl
);

    // ------------------------------------------------------------
    // storage and decode
    // ------------------------------------------------------------
    logic [15:0] word_lo_q;
    logic [15:0] word_lo_d;
    logic [15:0] word_mid_q;
    logic [15:0] word_mid_d;
    logic [15:0] word_hi_q;
    logic [15:0] word_hi_d;
    logic [47:0] cfg_all;
    logic [31:0] rdata_d;
    logic        chain_serial_out_d;
    logic [4:0]  line_d;
    drive_ctrl_t ctrl_d;
    logic        cutoff_q;
    logic        ceiling_q;
    logic        scan_order_reverse_q;
    logic [2:0]  fine_q;
    logic [2:0]  off_fast_q;
    on_slew_t    on_red_q;
    on_slew_t    on_green_q;
    on_slew_t    on_blue_q;
    logic [2:0]  coarse_q;
    logic [4:0]  dim_level_q;
    logic        iso_q;
    logic [4:0]  boost_level_q;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // level fields count from one, so a 4-bit code spans 1 to 16
    function automatic logic [4:0] level_of(input logic [3:0] code);
        return {1'b0, code} + 5'h01;
    endfunction

    // one compare for every word keeps the decode uniform
    function automatic logic word_hit(input logic [3:0] a, input logic [3:0] base);
        return a == base;
    endfunction

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire        hit_lo   = word_hit(addr, ADDR_CFG_LO);
    wire        hit_mid  = word_hit(addr, ADDR_CFG_MID);
    wire        hit_hi   = word_hit(addr, ADDR_CFG_HI);
    wire        hit_st   = word_hit(addr, ADDR_STATUS);
    wire        hit_cfg  = hit_lo || hit_mid || hit_hi;

    wire        wr_lo    = wr_stb && hit_lo;
    wire        wr_mid   = wr_stb && hit_mid;
    wire        wr_hi    = wr_stb && hit_hi;

    // only the low half of the bus carries register bits
    wire [15:0] wr_half  = wdata[15:0];

    // ------------------------------------------------------------
    // next word values
    // ------------------------------------------------------------
    // plain storage: reserved bits keep what was written
    assign word_lo_d  = wr_lo  ? wr_half : word_lo_q;
    assign word_mid_d = wr_mid ? wr_half : word_mid_q;
    assign word_hi_d  = wr_hi  ? wr_half : word_hi_q;

    assign cfg_all    = {word_hi_q, word_mid_q, word_lo_q};

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    wire [15:0] rd_word   = hit_lo  ? word_lo_q  :
                            hit_mid ? word_mid_q : word_hi_q;
    wire [31:0] rd_cfg    = {16'h0000, rd_word};
    wire [31:0] rd_status = {27'h0000000, physical_line};

    // status and unmapped reads never disturb the stored words
    assign rdata_d = !rd_stb ? 32'h0000_0000 :
                     hit_cfg ? rd_cfg :
                     hit_st  ? rd_status : 32'h0000_0000;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    wire       cutoff_bit   = cfg_all[POS_CUTOFF];
    wire       ceiling_bit  = cfg_all[POS_CEILING];
    wire       scan_order_reverse_bit = cfg_all[POS_SCAN_ORDER_REVERSE];
    wire       fine_red     = cfg_all[POS_FINE];
    wire       fine_green   = cfg_all[POS_FINE + 1];
    wire       fine_blue    = cfg_all[POS_FINE + 2];
    wire       off_red      = cfg_all[POS_OFF_SLEW];
    wire       off_green    = cfg_all[POS_OFF_SLEW + 1];
    wire       off_blue     = cfg_all[POS_OFF_SLEW + 2];
    wire [1:0] on_red       = cfg_all[POS_ON_SLEW +: 2];
    wire [1:0] on_green     = cfg_all[POS_ON_SLEW + 2 +: 2];
    wire [1:0] on_blue      = cfg_all[POS_ON_SLEW + 4 +: 2];
    wire       coarse_red   = cfg_all[POS_COARSE];
    wire       coarse_green = cfg_all[POS_COARSE + 1];
    wire       coarse_blue  = cfg_all[POS_COARSE + 2];

    wire [3:0] dim_code     = cfg_all[POS_FIRST_DIM +: 4];
    wire       iso_bit      = cfg_all[POS_ISO_EN];
    wire [3:0] boost_code   = cfg_all[POS_BOOST_LVL +: 4];
    wire       boost_on     = cfg_all[POS_BOOST_EN];

    // ------------------------------------------------------------
    // chain output
    // ------------------------------------------------------------
    // chain cut-off
    wire       chain_muted  = is_last_device && cutoff_bit && !readback_cmd;
    // readback must still reach the controller, so it is never muted
    assign chain_serial_out_d = chain_muted ? 1'b0 : shift_data;

    // ------------------------------------------------------------
    // line mapping
    // ------------------------------------------------------------
    // upper group reversal
    wire       upper_group  = logical_line >= LINE_HALF;
    wire [4:0] mirrored     = 5'(LINE_LAST - logical_line + LINE_HALF);
    assign line_d = (scan_order_reverse_bit && upper_group) ? mirrored : logical_line;

    // ------------------------------------------------------------
    // control word
    // ------------------------------------------------------------
    // cut-off mirror
    assign ctrl_d.chain_end_output_cutoff = cutoff_bit;
    assign ctrl_d.current_ceiling_select  = ceiling_bit;
    assign ctrl_d.scan_order_reverse      = scan_order_reverse_bit;
    assign ctrl_d.fine_enable             = {fine_blue, fine_green, fine_red};
    assign ctrl_d.turnoff_fast            = {off_blue, off_green, off_red};
    assign ctrl_d.red_turnon_slew         = on_slew_t'(on_red);
    assign ctrl_d.green_turnon_slew       = on_slew_t'(on_green);
    assign ctrl_d.blue_turnon_slew        = on_slew_t'(on_blue);
    assign ctrl_d.coarse_enable           = {coarse_blue, coarse_green, coarse_red};
    // dim level is code plus one
    assign ctrl_d.first_line_dim_level    = level_of(dim_code);
    assign ctrl_d.on_off_isolation_enable = iso_bit;
    assign ctrl_d.isolation_boost_level   = boost_on ? level_of(boost_code) : 5'h00;

    // ------------------------------------------------------------
    // word registers
    // ------------------------------------------------------------
    // word reset values
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            word_lo_q <= CFG_RESET[15:0];
        end else begin
            word_lo_q <= word_lo_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            word_mid_q <= CFG_RESET[31:16];
        end else begin
            word_mid_q <= word_mid_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            word_hi_q <= CFG_RESET[47:32];
        end else begin
            word_hi_q <= word_hi_d;
        end
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= rdata_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            chain_serial_out <= 1'b0;
        end else begin
            chain_serial_out <= chain_serial_out_d;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            physical_line <= 5'h00;
        end else begin
            physical_line <= line_d;
        end
    end

    // ------------------------------------------------------------
    // decoded outputs
    // ------------------------------------------------------------
    // controls read zero in reset and follow the words one edge later
    // cut-off flop
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            cutoff_q <= 1'b0;
        end else begin
            cutoff_q <= ctrl_d.chain_end_output_cutoff;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ceiling_q <= 1'b0;
        end else begin
            ceiling_q <= ctrl_d.current_ceiling_select;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            scan_order_reverse_q <= 1'b0;
        end else begin
            scan_order_reverse_q <= ctrl_d.scan_order_reverse;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            fine_q <= 3'h0;
        end else begin
            fine_q <= ctrl_d.fine_enable;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            off_fast_q <= 3'h0;
        end else begin
            off_fast_q <= ctrl_d.turnoff_fast;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            on_red_q <= SLEW_SLOWER;
        end else begin
            on_red_q <= ctrl_d.red_turnon_slew;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            on_green_q <= SLEW_SLOWER;
        end else begin
            on_green_q <= ctrl_d.green_turnon_slew;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            on_blue_q <= SLEW_SLOWER;
        end else begin
            on_blue_q <= ctrl_d.blue_turnon_slew;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            coarse_q <= 3'h0;
        end else begin
            coarse_q <= ctrl_d.coarse_enable;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            dim_level_q <= 5'h00;
        end else begin
            dim_level_q <= ctrl_d.first_line_dim_level;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            iso_q <= 1'b0;
        end else begin
            iso_q <= ctrl_d.on_off_isolation_enable;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            boost_level_q <= 5'h00;
        end else begin
            boost_level_q <= ctrl_d.isolation_boost_level;
        end
    end

    assign ctrl = '{
        chain_end_output_cutoff: cutoff_q,
        current_ceiling_select:  ceiling_q,
        scan_order_reverse:      scan_order_reverse_q,
        fine_enable:             fine_q,
        turnoff_fast:            off_fast_q,
        red_turnon_slew:         on_red_q,
        green_turnon_slew:       on_green_q,
        blue_turnon_slew:        on_blue_q,
        coarse_enable:           coarse_q,
        first_line_dim_level:    dim_level_q,
        on_off_isolation_enable: iso_q,
        isolation_boost_level:   boost_level_q
    };
endmodule

// *** verif/chain_ctrl_model.sv ***
// display controller model feeding the serial chain input
module chain_ctrl_model (
    input  wire logic ref_clk,
    output logic      shift_data,
    output logic      readback_cmd
);
    timeunit 1ns; timeprecision 1ns;
    logic [4:0] step_q = 5'h00;
    always @(posedge ref_clk) step_q <= step_q + 5'h01;
    assign shift_data = step_q[0] ^ step_q[2];
    assign readback_cmd = step_q[4] & step_q[3];
endmodule

// *** verif/channel_drive_config_properties.sv ***
// port assertions for the channel drive configuration register
module channel_drive_config_properties import channel_drive_pkg::*; (
    input wire logic ref_clk, nrst, wr_stb, rd_stb, is_last_device, readback_cmd,
    input wire logic shift_data, chain_serial_out,
    input wire logic [3:0] addr,
    input wire logic [31:0] wdata, rdata,
    input wire logic [4:0] logical_line, physical_line,
    input wire drive_ctrl_t ctrl
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_chain_cut: assert property (ctrl.chain_end_output_cutoff && $past(ctrl.chain_end_output_cutoff
        && is_last_device && !readback_cmd) |-> !chain_serial_out) else $error("cut leak");
    a_chain_pass: assert property ($past(nrst) && $past(!is_last_device || readback_cmd)
        |-> chain_serial_out == $past(shift_data)) else $error("chain pass");
    a_scan_order_reverse: assert property (ctrl.scan_order_reverse && $past(ctrl.scan_order_reverse)
        && $past(logical_line[4]) |-> physical_line == 5'(6'd47 - $past(logical_line)))
        else $error("scan_order_reverse");
    a_scan_plain: assert property ($past(nrst) && $past(!logical_line[4] || !ctrl.scan_order_reverse)
        && ctrl.scan_order_reverse == $past(ctrl.scan_order_reverse)
        |-> physical_line == $past(logical_line)) else $error("scan plain");
    a_lo_decode: assert property (wr_stb && addr == ADDR_CFG_LO |-> ##2
        ctrl.current_ceiling_select == $past(wdata[1], 2)) else $error("ceiling");
    a_mid_decode: assert property (wr_stb && addr == ADDR_CFG_MID |-> ##2
        ctrl.fine_enable == $past(wdata[2:0], 2) && ctrl.turnoff_fast == $past(wdata[5:3], 2)
        && ctrl.blue_turnon_slew == $past(wdata[11:10], 2)) else $error("mid");
    a_hi_decode: assert property (wr_stb && addr == ADDR_CFG_HI |-> ##2
        ctrl.coarse_enable == $past(wdata[2:0], 2) && ctrl.on_off_isolation_enable == $past(wdata[7], 2)
        && ctrl.first_line_dim_level == $past(wdata[6:3], 2) + 5'h1) else $error("hi");
    a_boost_level: assert property (wr_stb && addr == ADDR_CFG_HI |-> ##2 ctrl.isolation_boost_level
        == ($past(wdata[12], 2) ? $past(wdata[11:8], 2) + 5'h1 : 5'h0)) else $error("boost");
endmodule
bind channel_drive_config channel_drive_config_properties u_props (.ref_clk, .nrst, .wr_stb,
    .rd_stb, .is_last_device, .readback_cmd, .shift_data, .chain_serial_out, .addr, .wdata,
    .rdata, .logical_line, .physical_line, .ctrl);

// *** verif/led_driver_function_control_four_test.sv ***
// self-checking bench for the channel drive configuration register
module led_driver_function_control_four_test import channel_drive_pkg::*;;
    timeunit 1ns; timeprecision 1ns;
    logic ref_clk = 0, nrst = 0, wr_stb = 0, rd_stb = 0, is_last_device = 0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [4:0] logical_line = 5'h00, physical_line;
    logic chain_serial_out, shift_data, readback_cmd;
    drive_ctrl_t ctrl;
    int bad_count = 0, checks_done = 0;
    always #20 ref_clk = ~ref_clk;
    chain_ctrl_model PARTNER (.ref_clk, .shift_data, .readback_cmd);
    channel_drive_config DUT (.ref_clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
        .is_last_device, .readback_cmd, .shift_data, .chain_serial_out, .logical_line,
        .physical_line, .ctrl);
    task automatic chk(string n, logic [31:0] e, logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick; @(posedge ref_clk); #1; endtask
    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge ref_clk); addr <= a; wdata <= d; wr_stb <= 1'b1;
        @(posedge ref_clk); wr_stb <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] e);
        @(posedge ref_clk); addr <= a; rd_stb <= 1'b1;
        @(posedge ref_clk); rd_stb <= 1'b0; #1;
        chk("rdata", e, rdata);
    endtask
    task automatic t_reset;
        rd(ADDR_CFG_LO, 32'h403C);
        rd(ADDR_CFG_MID, 32'h0540);
        rd(ADDR_CFG_HI, 32'h0800);
        rd(4'h2, 32'h0);
        chk("dim", 32'h1, 32'(ctrl.first_line_dim_level));
    endtask
    task automatic t_codes;
        logic [31:0] d;
        for (int k = 0; k < 4; k++) begin
            // reserved bits kept at zero
            wr(ADDR_CFG_MID, k * 32'h0549);
            d = k * 32'h0528 | k | {k[0], 4'h0, k[1], 7'h0};
            wr(ADDR_CFG_HI, d);
            tick;
            chk("slew", 32'(k), 32'(ctrl.green_turnon_slew));
            chk("dim", 32'(k * 5 + 1), 32'(ctrl.first_line_dim_level));
            chk("boost", k[0] ? 32'(k * 5 + 1) : 32'h0, 32'(ctrl.isolation_boost_level));
            rd(ADDR_CFG_MID, k * 32'h0549);
        end
    endtask
    task automatic t_line(logic [4:0] l, logic [31:0] e);
        @(posedge ref_clk); logical_line <= l;
        rd(ADDR_STATUS, e);
    endtask
    task automatic t_chain(logic [31:0] lo, logic cut);
        logic rb, s;
        wr(ADDR_CFG_LO, lo);
        tick;
        chk("ceiling", {31'h0, lo[1]}, 32'(ctrl.current_ceiling_select));
        chk("scan", {31'h0, lo[14]}, 32'(ctrl.scan_order_reverse));
        repeat (32) begin
            rb = readback_cmd; s = shift_data;
            tick;
            chk("serial", {31'h0, s & !(cut & !rb)}, 32'(chain_serial_out));
        end
    endtask
    task automatic complete_run;
        if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset;
        t_codes;
        t_line(5'h11, 32'h1E);
        t_line(5'h05, 32'h05);
        is_last_device <= 1'b1;
        t_chain(32'h403F, 1'b1);
        t_chain(32'h003C, 1'b0);
        t_line(5'h11, 32'h11);
        is_last_device <= 1'b0;
        t_chain(32'h403D, 1'b0);
        complete_run;
    end
endmodule
